// ==== hdl/tbdm_map.svh ====
`ifndef TBDM_MAP_SVH
`define TBDM_MAP_SVH
`define TBDM_NUM_BANKS      8
`define TBDM_BANK_BITS      3
`define TBDM_LATENCY        5
`define TBDM_STD_BYTES      32768
`define TBDM_ML_BYTES       65536
`define TBDM_STD_REACH      131072
`define TBDM_ML_REACH       262144
`define TBDM_NUM_REQ        7
`define TBDM_REQ_CORE       0
`define TBDM_REQ_NORTH      1
`define TBDM_REQ_SOUTH      2
`define TBDM_REQ_EAST       3
`define TBDM_REQ_WEST       4
`define TBDM_REQ_DMA_WR     5
`define TBDM_REQ_DMA_RD     6
`endif

// ==== hdl/tbdm_pkg.sv ====
package tbdm_pkg;
    typedef enum logic [1:0] {
        TBDM_DMA_IDLE = 2'b00,
        TBDM_DMA_IN   = 2'b01,
        TBDM_DMA_OUT  = 2'b10,
        TBDM_DMA_LOOP = 2'b11
    } tbdm_dma_state_t;
endpackage : tbdm_pkg

// ==== hdl/tbdm_bank.sv ====
`timescale 1ns/1ps
`include "tbdm_map.svh"
// One single-port bank with an even-parity bit per word, fixed pipeline.
module tbdm_bank #(
    parameter int DATA_W = 32,
    parameter int ADDR_W = 10
) (
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire logic              reqValid,
    input  wire logic              reqWrite,
    input  wire logic [ADDR_W-1:0] reqAddr,
    input  wire logic [DATA_W-1:0] reqWdata,
    input  wire logic              injectParity,
    output logic                   rspValid,
    output logic                   rspWrite,
    output logic [DATA_W-1:0]      rspRdata,
    output logic                   rspParityErr
);
    localparam int LAT = `TBDM_LATENCY;

    // The pipe shifts need at least three stages to be expressible
    if (LAT < 3 || ADDR_W < 1 || DATA_W < 1) begin : g_chk_param
        $error("tbdm_bank: unsupported parameters");
    end
    logic [DATA_W:0]     memArr [2**ADDR_W];
    logic [LAT-2:0]      vldPipe_q;
    logic [LAT-2:0]      wrPipe_q;
    logic [DATA_W:0]     dataPipe_q [LAT-1];
    logic [DATA_W:0]     rdWord;

    always_ff @(posedge clk) begin
        if (reqValid && reqWrite) begin // see [R05]
            memArr[reqAddr] <= {(^reqWdata) ^ injectParity, reqWdata};
        end
    end

    assign rdWord = memArr[reqAddr];

    // Stage 0 captures the array; remaining stages just age the result
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            vldPipe_q <= '0;
            wrPipe_q  <= '0;
        end else begin
            vldPipe_q <= {vldPipe_q[LAT-3:0], reqValid}; // see [R03]
            wrPipe_q  <= {wrPipe_q[LAT-3:0], reqWrite};
        end
    end

    always_ff @(posedge clk) begin
        dataPipe_q[0] <= rdWord;
        for (int i = 1; i < LAT - 1; i++) begin
            dataPipe_q[i] <= dataPipe_q[i-1];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rspValid     <= 1'b0;
            rspWrite     <= 1'b0;
            rspRdata     <= '0;
            rspParityErr <= 1'b0;
        end else begin
            rspValid     <= vldPipe_q[LAT-2];
            rspWrite     <= wrPipe_q[LAT-2];
            rspRdata     <= dataPipe_q[LAT-2][DATA_W-1:0];
            rspParityErr <= vldPipe_q[LAT-2] && !wrPipe_q[LAT-2]
                            && (^dataPipe_q[LAT-2]); // see [R05]
        end
    end
endmodule : tbdm_bank

// ==== hdl/tbdm_memory.sv ====
`timescale 1ns/1ps
`include "tbdm_map.svh"
// Operation
// [R01] 32KB standard or 64KB ML storage split into eight single-port banks.
// [R02] Up to eight accesses per cycle, one per bank, on distinct banks; the code has seven requesters, so at most seven.
// [R03] Each access completes five cycles after it is accepted.
// [R04] Bank conflicts stall the loser, which holds its request until granted.
// [R05] Parity is stored per word, checked on read, errors flagged.
// [R06] DMA writes inbound stream, reads outbound stream, or loops stream in.
// [R07] Four neighbour cores access here; each core reaches 128KB or 256KB.
// [R08] Bank from low word address bits; fixed priority, one grant per bank.
module tbdm_memory #(
    parameter bit MlVariant = 1'b0,
    parameter int DATA_W    = 32
) (
    input  wire logic                          clk,
    input  wire logic                          rst_b,
    input  wire logic [`TBDM_NUM_REQ-1:0]      reqValid,
    input  wire logic [`TBDM_NUM_REQ-1:0]      reqWrite,
    input  wire logic [`TBDM_NUM_REQ*16-1:0]   reqAddr,
    input  wire logic [`TBDM_NUM_REQ*DATA_W-1:0] reqWdata,
    output logic      [`TBDM_NUM_REQ-1:0]      reqStall,
    output logic      [`TBDM_NUM_REQ-1:0]      rspValid,
    output logic      [`TBDM_NUM_REQ*DATA_W-1:0] rspRdata,
    output logic                               parityErr,
    input  wire logic                          injectParity,
    input  wire logic [1:0]                    dmaMode,
    input  wire logic                          dmaStart,
    input  wire logic [15:0]                   dmaBase,
    input  wire logic [15:0]                   dmaLen,
    input  wire logic                          sInValid,
    output logic                               sInReady,
    input  wire logic [DATA_W-1:0]             sInData,
    output logic                               sOutValid,
    input  wire logic                          sOutReady,
    output logic      [DATA_W-1:0]             sOutData,
    output logic                               dmaBusy
);
    localparam int NB     = `TBDM_NUM_BANKS;
    localparam int NR     = `TBDM_NUM_REQ;
    localparam int BB     = `TBDM_BANK_BITS;
    localparam int LAT    = `TBDM_LATENCY;
    localparam int BYTES  = MlVariant ? `TBDM_ML_BYTES : `TBDM_STD_BYTES;
    localparam int REACH  = MlVariant ? `TBDM_ML_REACH : `TBDM_STD_REACH;
    localparam int WORDS  = BYTES / (DATA_W / 8);
    localparam int BANK_W = WORDS / NB;
    localparam int BA_W   = $clog2(BANK_W);
    localparam int WA_W   = BA_W + BB;

    if (DATA_W != 32) begin : g_chk_width
        $error("tbdm_memory: DATA_W must be 32");
    end

    // Neighbour ports 1 to 4 widen one core's reach to four local memories
    if (REACH != 4 * BYTES) begin : g_chk_reach // see [R07]
        $error("tbdm_memory: reach mismatch");
    end

    function automatic logic [BB-1:0] bankOf(input logic [15:0] a);
        return a[BB-1:0]; // see [R08]
    endfunction : bankOf

    // DMA sequencer: drives requester slots 5 (write) and 6 (read)
    tbdm_pkg::tbdm_dma_state_t dmaState_q;
    logic [15:0] dmaPtr_q;
    logic [15:0] dmaLeft_q;
    logic [15:0] dmaRdPtr_q;
    logic [15:0] dmaRdLeft_q;
    logic [2:0]  dmaInFlight_q;
    logic        dmaWrReq;
    logic        dmaRdReq;
    logic        dmaRdRet;

    logic [NR-1:0]      effValid;
    logic [NR-1:0]      effWrite;
    logic [15:0]        effAddr  [NR];
    logic [DATA_W-1:0]  effWdata [NR];
    logic [NR-1:0]      grant;
    logic [NB-1:0]      bankHit;

    always_comb begin
        for (int r = 0; r < NR; r++) begin
            effValid[r] = reqValid[r];
            effWrite[r] = reqWrite[r];
            effAddr[r]  = reqAddr[r*16 +: 16];
            effWdata[r] = reqWdata[r*DATA_W +: DATA_W];
        end
        effValid[`TBDM_REQ_DMA_WR] = dmaWrReq;
        effWrite[`TBDM_REQ_DMA_WR] = 1'b1;
        effAddr[`TBDM_REQ_DMA_WR]  = dmaPtr_q;
        effWdata[`TBDM_REQ_DMA_WR] = sInData;
        effValid[`TBDM_REQ_DMA_RD] = dmaRdReq;
        effWrite[`TBDM_REQ_DMA_RD] = 1'b0;
        effAddr[`TBDM_REQ_DMA_RD]  = dmaRdPtr_q;
        effWdata[`TBDM_REQ_DMA_RD] = '0;
    end

    // Fixed priority: core, then N/S/E/W, then DMA; lowest index wins
    always_comb begin
        bankHit = '0;
        grant   = '0;
        for (int r = 0; r < NR; r++) begin
            if (effValid[r] && !bankHit[bankOf(effAddr[r])]) begin
                grant[r] = 1'b1; // see [R08] see [R02]
                bankHit[bankOf(effAddr[r])] = 1'b1;
            end
        end
    end

    // Losers must hold request steady while stalled
    assign reqStall = effValid & ~grant; // see [R04]

    logic [NB-1:0]       bkValid;
    logic [NB-1:0]       bkWrite;
    logic [BA_W-1:0]     bkAddr  [NB];
    logic [DATA_W-1:0]   bkWdata [NB];
    logic [NR-1:0]       bkOwner [NB];
    logic [NB-1:0]       bkRspValid;
    logic [NB-1:0]       bkRspWrite;
    logic [NB-1:0]       bkErr;
    logic [DATA_W-1:0]   bkRdata [NB];
    logic [NR-1:0]       ownPipe_q [NB][LAT];

    always_comb begin
        for (int b = 0; b < NB; b++) begin
            bkValid[b] = 1'b0;
            bkWrite[b] = 1'b0;
            bkAddr[b]  = '0;
            bkWdata[b] = '0;
            bkOwner[b] = '0;
            for (int r = 0; r < NR; r++) begin
                if (grant[r] && bankOf(effAddr[r]) == BB'(b)) begin
                    bkValid[b] = 1'b1;
                    bkWrite[b] = effWrite[r];
                    bkAddr[b]  = effAddr[r][BB +: BA_W]; // see [R01]
                    bkWdata[b] = effWdata[r];
                    bkOwner[b][r] = 1'b1;
                end
            end
        end
    end

    generate
        for (genvar b = 0; b < NB; b++) begin : g_bank
            tbdm_bank #(.DATA_W(DATA_W), .ADDR_W(BA_W)) u_bank (
                .clk          (clk),
                .rst_b        (rst_b),
                .reqValid     (bkValid[b]),
                .reqWrite     (bkWrite[b]),
                .reqAddr      (bkAddr[b]),
                .reqWdata     (bkWdata[b]),
                .injectParity (injectParity),
                .rspValid     (bkRspValid[b]),
                .rspWrite     (bkRspWrite[b]),
                .rspRdata     (bkRdata[b]),
                .rspParityErr (bkErr[b])
            );
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    for (int s = 0; s < LAT; s++) ownPipe_q[b][s] <= '0;
                end else begin
                    ownPipe_q[b][0] <= bkOwner[b]; // see [R03]
                    for (int s = 1; s < LAT; s++) begin
                        ownPipe_q[b][s] <= ownPipe_q[b][s-1];
                    end
                end
            end
        end
    endgenerate

    // Owner tag is aged alongside the bank pipe, so routing is static
    always_comb begin
        rspValid = '0;
        rspRdata = '0;
        dmaRdRet = 1'b0;
        sOutData = '0;
        for (int b = 0; b < NB; b++) begin
            for (int r = 0; r < NR; r++) begin
                if (bkRspValid[b] && ownPipe_q[b][LAT-1][r]) begin
                    rspValid[r] = 1'b1;
                    rspRdata[r*DATA_W +: DATA_W] = bkRdata[b];
                end
            end
        end
        dmaRdRet = rspValid[`TBDM_REQ_DMA_RD];
        sOutData = rspRdata[`TBDM_REQ_DMA_RD*DATA_W +: DATA_W];
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            parityErr <= 1'b0;
        end else begin
            parityErr <= |bkErr; // see [R05]
        end
    end

    // No outbound buffer: reads launch only when sink is ready with slack
    assign sOutValid = dmaRdRet;
    assign sInReady  = dmaWrReq && grant[`TBDM_REQ_DMA_WR];
    assign dmaWrReq  = (dmaState_q == tbdm_pkg::TBDM_DMA_IN ||
                        dmaState_q == tbdm_pkg::TBDM_DMA_LOOP) &&
                       dmaLeft_q != 16'h0000 && sInValid;
    assign dmaRdReq  = (dmaState_q == tbdm_pkg::TBDM_DMA_OUT ||
                        (dmaState_q == tbdm_pkg::TBDM_DMA_LOOP &&
                         dmaRdLeft_q > dmaLeft_q)) &&
                       dmaRdLeft_q != 16'h0000 && sOutReady &&
                       dmaInFlight_q == 3'h0;
    assign dmaBusy   = dmaState_q != tbdm_pkg::TBDM_DMA_IDLE;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dmaState_q    <= tbdm_pkg::TBDM_DMA_IDLE;
            dmaPtr_q      <= 16'h0000;
            dmaLeft_q     <= 16'h0000;
            dmaRdPtr_q    <= 16'h0000;
            dmaRdLeft_q   <= 16'h0000;
            dmaInFlight_q <= 3'h0;
        end else begin
            if (dmaState_q == tbdm_pkg::TBDM_DMA_IDLE) begin
                if (dmaStart && dmaMode != 2'b00) begin // see [R06]
                    dmaState_q  <= tbdm_pkg::tbdm_dma_state_t'(dmaMode);
                    dmaPtr_q    <= dmaBase;
                    dmaRdPtr_q  <= dmaBase;
                    dmaLeft_q   <= dmaLen;
                    dmaRdLeft_q <= dmaLen;
                end
            end else begin
                if (sInReady) begin
                    dmaPtr_q  <= dmaPtr_q + 16'h0001;
                    dmaLeft_q <= dmaLeft_q - 16'h0001;
                end
                if (dmaRdReq && grant[`TBDM_REQ_DMA_RD]) begin
                    dmaRdPtr_q  <= dmaRdPtr_q + 16'h0001;
                    dmaRdLeft_q <= dmaRdLeft_q - 16'h0001;
                    dmaInFlight_q <= 3'(LAT);
                end else if (dmaInFlight_q != 3'h0) begin
                    dmaInFlight_q <= dmaInFlight_q - 3'h1;
                end
                if (dmaState_q == tbdm_pkg::TBDM_DMA_IN &&
                    dmaLeft_q == 16'h0000) begin
                    dmaState_q <= tbdm_pkg::TBDM_DMA_IDLE;
                end else if (dmaState_q != tbdm_pkg::TBDM_DMA_IN &&
                             dmaRdLeft_q == 16'h0000 &&
                             dmaInFlight_q == 3'h0) begin
                    dmaState_q <= tbdm_pkg::TBDM_DMA_IDLE;
                end
            end
        end
    end

    property p_latency;
        @(posedge clk) disable iff (!rst_b)
        (grant[`TBDM_REQ_CORE]) |-> ##5 rspValid[`TBDM_REQ_CORE];
    endproperty
    a_latency: assert property (p_latency) // see [R03]
        else $error("latency not five");

    property p_stall;
        @(posedge clk) disable iff (!rst_b)
        (reqValid[`TBDM_REQ_NORTH] && reqValid[`TBDM_REQ_CORE] &&
         reqAddr[2:0] == reqAddr[18:16]) |-> reqStall[`TBDM_REQ_NORTH];
    endproperty
    a_stall: assert property (p_stall) // see [R04]
        else $error("conflict not stalled");

    // Two grants on one bank would show as fewer busy banks than grants
    property p_onegrant;
        @(posedge clk) disable iff (!rst_b)
        $countones(grant) == $countones(bkValid);
    endproperty
    a_onegrant: assert property (p_onegrant) // see [R08]
        else $error("bad grant");

    property p_core_first;
        @(posedge clk) disable iff (!rst_b)
        reqValid[`TBDM_REQ_CORE] |-> !reqStall[`TBDM_REQ_CORE] &&
        (!reqValid[`TBDM_REQ_NORTH] || reqAddr[2:0] == reqAddr[18:16] ||
         !reqStall[`TBDM_REQ_NORTH]);
    endproperty
    a_core_first: assert property (p_core_first) // see [R02]
        else $error("distinct banks not served together");

    sequence s_wrDone;
        grant[`TBDM_REQ_DMA_WR] ##5 rspValid[`TBDM_REQ_DMA_WR];
    endsequence
    property p_dma;
        @(posedge clk) disable iff (!rst_b)
        sInReady |-> s_wrDone;
    endproperty
    a_dma: assert property (p_dma) // see [R06]
        else $error("dma write lost");

    // Writes never check parity, so only a read answer may raise the flag
    property p_parity;
        @(posedge clk) disable iff (!rst_b)
        parityErr |-> $past(|(bkRspValid & ~bkRspWrite));
    endproperty
    a_parity: assert property (p_parity) // see [R05]
        else $error("spurious parity");
endmodule : tbdm_memory

// ==== test/tbdm_core_model.sv ====
`timescale 1ns/1ps
// Requester core: keeps its access up while stalled, then lets go.
module tbdm_core_model (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        start,
    input  wire logic        wr,
    input  wire logic [15:0] addr,
    input  wire logic [31:0] wdata,
    input  wire logic        stall,
    output logic             valid,
    output logic             write,
    output logic      [15:0] aAddr,
    output logic      [31:0] aWdata,
    output logic             taken
);
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            valid  <= 1'b0;
            write  <= 1'b0;
            aAddr  <= 16'h0000;
            aWdata <= 32'h0000_0000;
            taken  <= 1'b0;
        end else begin
            taken <= valid && !stall;
            if (valid && !stall) begin
                // Released lines invert so stale values cannot pass
                valid  <= 1'b0;
                aAddr  <= ~aAddr;
                aWdata <= ~aWdata;
            end else if (!valid && start) begin
                valid  <= 1'b1;
                write  <= wr;
                aAddr  <= addr;
                aWdata <= wdata;
            end
        end
    end
endmodule : tbdm_core_model

// ==== test/testbench.sv ====
`timescale 1ns/1ps
module testbench;
    logic         clk, rst_b, parityErr, injectParity, dmaStart;
    logic         sInValid, sInReady, sOutValid, sOutReady, dmaBusy;
    logic [6:0]   reqValid, reqWrite, reqStall, rspValid;
    logic [111:0] reqAddr;
    logic [223:0] reqWdata, rspRdata;
    logic [1:0]   dmaMode;
    logic [15:0]  dmaBase, dmaLen;
    logic [31:0]  sInData, sOutData, d;
    logic [4:0]   start, wr, taken;
    logic [15:0]  ad [5];
    logic [31:0]  wd [5];
    logic [31:0]  rd [5];
    int           tk [5];
    int           rs [5];
    int           pe, cyc, error_cnt, cmp_count;

    // Slots 5 and 6 belong to the internal stream engine
    assign reqValid[6:5]    = 2'b00;
    assign reqWrite[6:5]    = 2'b00;
    assign reqAddr[111:80]  = 32'h0000_0000;
    assign reqWdata[223:160] = 64'h0;

    tbdm_memory #(.MlVariant(1'b0), .DATA_W(32)) u_dut (
        .clk(clk), .rst_b(rst_b), .reqValid(reqValid),
        .reqWrite(reqWrite), .reqAddr(reqAddr), .reqWdata(reqWdata),
        .reqStall(reqStall), .rspValid(rspValid), .rspRdata(rspRdata),
        .parityErr(parityErr), .injectParity(injectParity),
        .dmaMode(dmaMode), .dmaStart(dmaStart), .dmaBase(dmaBase),
        .dmaLen(dmaLen), .sInValid(sInValid), .sInReady(sInReady),
        .sInData(sInData), .sOutValid(sOutValid),
        .sOutReady(sOutReady), .sOutData(sOutData), .dmaBusy(dmaBusy));

    for (genvar g = 0; g < 5; g++) begin : g_req
        tbdm_core_model u_req (
            .clk(clk), .rst_b(rst_b), .start(start[g]), .wr(wr[g]),
            .addr(ad[g]), .wdata(wd[g]), .stall(reqStall[g]),
            .valid(reqValid[g]), .write(reqWrite[g]),
            .aAddr(reqAddr[g*16+:16]), .aWdata(reqWdata[g*32+:32]),
            .taken(taken[g]));
    end

    always #20 clk = ~clk;

    // Cycle stamps of grants, answers and parity flags
    always @(posedge clk) begin
        for (int i = 0; i < 5; i++) begin
            // Taken is registered, so it lags the accepting edge by one
            if (taken[i] === 1'b1) tk[i] = cyc - 1;
            if (rspValid[i] === 1'b1) begin
                rs[i] = cyc;
                rd[i] = rspRdata[i*32+:32];
            end
        end
        if (parityErr === 1'b1) pe = cyc;
        cyc <= cyc + 1;
    end

    task automatic cmp(input string nm, input logic [31:0] e, g);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp

    task automatic close_out;
        $display("checks %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : close_out

    task automatic clr;
        @(negedge clk);
        for (int i = 0; i < 5; i++) begin
            tk[i] = -1;
            rs[i] = -1;
        end
        pe = -1;
    endtask : clr

    task automatic acc(input int i, input logic w, input logic [15:0] a,
                       input logic [31:0] v);
        wr[i] <= w;
        ad[i] <= a;
        wd[i] <= v;
    endtask : acc

    task automatic go(input logic [4:0] m);
        @(posedge clk);
        start <= m;
        @(posedge clk);
        start <= 5'h00;
    endtask : go

    // Bounded wait for one answer, then its distance from the grant
    task automatic fin(input int i, output logic [31:0] v);
        int n;
        n = 0;
        while (rs[i] < 0 && n < 60) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (rs[i] < 0) begin
            error_cnt++;
            $display("mismatch answer expected 1 seen 0");
            close_out;
        end
        cmp("latency", 32'h5, rs[i] - tk[i]);
        v = rd[i];
    endtask : fin

    function automatic logic [31:0] pat(input logic [15:0] s, input int k);
        return {s, k[15:0]};
    endfunction : pat

    task automatic sc_single;
        clr;
        acc(0, 1'b1, 16'h1fff, 32'h1234_abcd);
        go(5'h01);
        fin(0, d);
        clr;
        acc(0, 1'b0, 16'h1fff, 32'h0);
        go(5'h01);
        fin(0, d);
        repeat (2) @(posedge clk);
        #1;
        cmp("top word", 32'h1234_abcd, d);
        cmp("clean read", 32'hffff_ffff, pe);
    endtask : sc_single

    task automatic sc_par;
        for (int w = 1; w >= 0; w--) begin
            clr;
            for (int i = 0; i < 5; i++)
                acc(i, w[0], 16'h0100 + i[15:0], 32'hbeef_0000 + i);
            go(5'h1f);
            for (int i = 0; i < 5; i++) begin
                fin(i, d);
                cmp("same grant", tk[0], tk[i]);
                if (w == 0) cmp("neighbour", 32'hbeef_0000 + i, d);
            end
        end
    endtask : sc_par

    task automatic sc_conf;
        clr;
        acc(0, 1'b1, 16'h0013, 32'h0000_aaaa);
        acc(1, 1'b1, 16'h002b, 32'h0000_bbbb);
        go(5'h03);
        fin(0, d);
        fin(1, d);
        cmp("loser delay", 32'h1, tk[1] - tk[0]);
        clr;
        acc(0, 1'b0, 16'h002b, 32'h0);
        acc(1, 1'b0, 16'h0013, 32'h0);
        go(5'h03);
        fin(0, d);
        cmp("held write", 32'h0000_bbbb, d);
        fin(1, d);
        cmp("held write", 32'h0000_aaaa, d);
    endtask : sc_conf

    task automatic sc_perr;
        clr;
        injectParity <= 1'b1;
        acc(0, 1'b1, 16'h0044, 32'h5a5a_5a5a);
        go(5'h01);
        fin(0, d);
        injectParity <= 1'b0;
        clr;
        acc(0, 1'b0, 16'h0044, 32'h0);
        go(5'h01);
        fin(0, d);
        repeat (2) @(posedge clk);
        #1;
        cmp("parity flag", 32'h1, pe - rs[0]);
    endtask : sc_perr

    // Mode 3 feeds words in and expects the same words back out
    task automatic sc_dma(input logic [1:0] m, input logic [15:0] b, n, s);
        int k, o, g, wi, wo;
        k = 0;
        o = 0;
        g = 0;
        wi = (m != 2'd2) ? n : 0;
        wo = (m != 2'd1) ? n : 0;
        @(posedge clk);
        dmaMode <= m;
        dmaBase <= b;
        dmaLen <= n;
        dmaStart <= 1'b1;
        @(posedge clk);
        dmaStart <= 1'b0;
        sInValid <= (wi > 0);
        sInData <= pat(s, 0);
        while (g < 300 && !(k == wi && o == wo && dmaBusy === 1'b0)) begin
            @(posedge clk);
            g++;
            if (sInValid && sInReady === 1'b1) begin
                k++;
                sInData <= pat(s, k);
                sInValid <= (k < wi);
            end
            if (sOutValid === 1'b1) begin
                cmp("stream out", pat(s, o), sOutData);
                o++;
            end
        end
        if (g >= 300) begin
            error_cnt++;
            $display("mismatch stream done expected 1 seen 0");
            close_out;
        end
    endtask : sc_dma

    initial begin
        clk = 1'b0;
        rst_b = 1'b0;
        injectParity = 1'b0;
        dmaMode = 2'd0;
        dmaStart = 1'b0;
        dmaBase = 16'h0;
        dmaLen = 16'h0;
        sInValid = 1'b0;
        sInData = 32'h0;
        sOutReady = 1'b1;
        start = 5'h00;
        wr = 5'h00;
        cyc = 0;
        error_cnt = 0;
        cmp_count = 0;
        for (int i = 0; i < 5; i++) begin
            ad[i] = 16'h0;
            wd[i] = 32'h0;
        end
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        sc_single;
        sc_par;
        sc_conf;
        sc_perr;
        sc_dma(2'd1, 16'h0200, 16'd4, 16'hd00d);
        sc_dma(2'd2, 16'h0200, 16'd4, 16'hd00d);
        sc_dma(2'd3, 16'h0300, 16'd3, 16'h1eaf);
        close_out;
    end
endmodule : testbench
